// File: src/trail_trace_tx.sv
// Trail trace identifier transmitter: APB register file, 16-byte
// identifier store and a byte stream toward the framer overhead path.
// Assumes an APB master on I_CLK and a framer that takes one byte
// (first transmitted bit in bit 7) per cycle in which it raises ready.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "trail_trace_tx_params.svh"

// Behaviour
// - Alignment enabled: first sent bit is alignment
// - Alignment disabled: stored bytes sent unmodified
// - Idle set sends zeros, else identifier
// - Inversion set inverts every outgoing bit
// - Reorder off sends bit 7 first
// - Four-bit pointer selects byte, zero first
// - Pointer increments per data port access, wraps to zero
// - Data port reads/writes pointed byte, advances
module trail_trace_tx
    import trail_trace_tx_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int BUF_DEPTH = 2
)
(
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    input  wire logic [3:0]        I_PSTRB,
    output logic      [31:0]       O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    output logic      [7:0]        O_TX_BYTE,
    output logic                   O_TX_VALID,
    input  wire logic              I_TX_READY
);

    localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);

    // The buffer pointers wrap by overflow, so the depth must be 2**n
    if (ADDR_W < 10 || ADDR_W > 32)
        $error("ADDR_W must lie between 10 and 32");
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
        $error("BUF_DEPTH must be a power of two, at least 2");

    typedef struct packed {
        ctrl_type                                     ctrl;
        logic [`TT_PTR_W-1:0]                         ptr;
        logic [`TT_ID_BYTES-1:0][`TT_BYTE_W-1:0]      mem;
        logic [31:0]                                  rdata;
        logic [`TT_PTR_W-1:0]                         tx_idx;
        logic [BUF_DEPTH-1:0][`TT_BYTE_W-1:0]         fifo;
        logic [AW-1:0]                                wr;
        logic [AW-1:0]                                rd;
        logic [CW-1:0]                                cnt;
    } state_type;

    state_type             s_r;
    state_type             s_nxt;
    reg_sel_type           sel;
    logic                  setup;
    logic                  access;
    logic                  wr_en;
    logic                  push;
    logic                  pop;
    logic [7:0]            push_byte;
    logic [7:0]            cur_byte;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    function automatic reg_sel_type decode(input logic [ADDR_W-1:0] a);
        if (a == byte_addr(`TT_CTRL_IDX))
            decode = SEL_CTRL;
        else if (a == byte_addr(`TT_PTR_IDX))
            decode = SEL_PTR;
        else if (a == byte_addr(`TT_DATA_IDX))
            decode = SEL_DATA;
        else
            decode = SEL_NONE;
    endfunction

    function automatic logic [7:0] reverse8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
            r[i] = b[7 - i];
        reverse8 = r;
    endfunction

    // Bit 7 of the result is the first bit on the line
    function automatic logic [7:0] build_byte(input ctrl_type c,
                                              input logic [7:0] d,
                                              input logic [3:0] idx);
        logic [7:0] b;
        b = c.send_zero_identifier ? 8'h00 : d;
        if (c.lsb_first_enable)
            b = reverse8(b);
        // Alignment marks byte zero so the far end can find the start
        if (!c.align_insert_disable)
            b[7] = (idx == 4'h0);
        if (c.output_invert_enable)
            b = ~b;
        build_byte = b;
    endfunction

    assign sel       = decode(I_PADDR);
    assign setup     = I_PSEL & ~I_PENABLE;
    assign access    = I_PSEL & I_PENABLE;
    assign wr_en     = access & I_PWRITE & I_PSTRB[0];
    assign cur_byte  = s_r.mem[s_r.tx_idx];
    assign push_byte = build_byte(s_r.ctrl, cur_byte, s_r.tx_idx);
    // Producer stalls whenever the buffer is full
    assign push      = (s_r.cnt != CW'(BUF_DEPTH));
    assign pop       = O_TX_VALID & I_TX_READY;

    assign O_PRDATA   = s_r.rdata;
    assign O_PREADY   = 1'b1;
    assign O_PSLVERR  = access & (sel == SEL_NONE);
    assign O_TX_BYTE  = s_r.fifo[s_r.rd];
    assign O_TX_VALID = (s_r.cnt != '0);

    always_comb
    begin
        s_nxt = s_r;
        // Read data is latched in the setup phase so PRDATA is a flop
        if (setup && !I_PWRITE)
        begin
            if (sel == SEL_CTRL)
                s_nxt.rdata = {28'h0, s_r.ctrl};
            else if (sel == SEL_PTR)
                s_nxt.rdata = {28'h0, s_r.ptr};
            else if (sel == SEL_DATA)
                s_nxt.rdata = {24'h0, s_r.mem[s_r.ptr]};
            else
                s_nxt.rdata = 32'h0;
        end
        if (wr_en && sel == SEL_CTRL)
            s_nxt.ctrl = ctrl_type'(I_PWDATA[`TT_CTRL_W-1:0]);
        if (wr_en && sel == SEL_PTR)
            s_nxt.ptr = I_PWDATA[`TT_PTR_W-1:0];
        if (wr_en && sel == SEL_DATA)
            s_nxt.mem[s_r.ptr] = I_PWDATA[7:0];
        // Any completed data port access moves on, byte lanes aside
        if (access && sel == SEL_DATA)
            s_nxt.ptr = s_r.ptr + 4'h1;
        if (push)
        begin
            s_nxt.fifo[s_r.wr] = push_byte;
            s_nxt.wr           = s_r.wr + AW'(1);
            s_nxt.tx_idx       = s_r.tx_idx + 4'h1;
        end
        if (pop)
            s_nxt.rd = s_r.rd + AW'(1);
        s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_SYS_RST)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    a_align_bit_insert: assert property (
        push && !s_r.ctrl.align_insert_disable |->
        push_byte[7] == (s_r.ctrl.output_invert_enable ^
                         (s_r.tx_idx == 4'h0)))
        else $error("Alignment bit wrong in first sent position");

    a_raw_byte_pass: assert property (
        push && s_r.ctrl == 4'b1000 |-> ##1
        O_TX_VALID && s_r.fifo[$past(s_r.wr)] == $past(cur_byte))
        else $error("Byte altered with alignment disabled");

    a_idle_all_zero: assert property (
        push && s_r.ctrl.send_zero_identifier &&
        s_r.ctrl.align_insert_disable |->
        push_byte == {8{s_r.ctrl.output_invert_enable}})
        else $error("Idle identifier not all zeros");

    a_invert_output: assert property (
        push && s_r.ctrl == 4'b1010 |-> push_byte == ~cur_byte)
        else $error("Output inversion missing");

    a_lsb_order: assert property (
        push && s_r.ctrl == 4'b1001 |->
        push_byte == reverse8(cur_byte))
        else $error("Least significant bit not sent first");

    a_ptr_step_wrap: assert property (
        access && sel == SEL_DATA |=>
        s_r.ptr == $past(s_r.ptr) + 4'h1)
        else $error("Pointer did not advance after data access");

    a_data_read: assert property (
        setup && !I_PWRITE && sel == SEL_DATA |=>
        O_PRDATA == {24'h0, $past(s_r.mem[s_r.ptr])})
        else $error("Data port returned wrong byte");

    a_tx_sequence: assert property (
        push |=> s_r.tx_idx == $past(s_r.tx_idx) + 4'h1)
        else $error("Identifier bytes sent out of order");

    a_reset_clear: assert property (
        $past(I_SYS_RST) |-> s_r.ctrl == '0 && s_r.ptr == '0 &&
        !O_TX_VALID)
        else $error("State not cleared by reset");

    a_stall_hold: assert property (
        O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_BYTE))
        else $error("Byte lost or changed during stall");

    // Register side: read data comes from the setup edge, so it must
    // reflect the state seen there and hold until the next read setup
    a_ctrl_read: assert property (
        setup && !I_PWRITE && sel == SEL_CTRL |=>
        O_PRDATA == {28'h0, $past(s_r.ctrl)})
        else $error("Control register read back wrong");

    a_ptr_read: assert property (
        setup && !I_PWRITE && sel == SEL_PTR |=>
        O_PRDATA == {28'h0, $past(s_r.ptr)})
        else $error("Pointer register read back wrong");

    a_hole_read: assert property (
        setup && !I_PWRITE && sel == SEL_NONE |=>
        O_PRDATA == 32'h0)
        else $error("Unmapped read returned nonzero data");

    a_hole_error: assert property (
        access && sel == SEL_NONE |-> O_PSLVERR)
        else $error("Unmapped access gave no error response");

    a_slverr_quiet: assert property (
        !access |-> !O_PSLVERR)
        else $error("Error response outside an access phase");

    a_ready_const: assert property (
        O_PREADY)
        else $error("Ready dropped; no wait states are expected");

    a_rdata_hold: assert property (
        !(setup && !I_PWRITE) |=> $stable(O_PRDATA))
        else $error("Read data changed without a read setup");

    a_ctrl_write: assert property (
        wr_en && sel == SEL_CTRL |=>
        s_r.ctrl == $past(I_PWDATA[3:0]))
        else $error("Control write did not land");

    a_ptr_write: assert property (
        wr_en && sel == SEL_PTR |=>
        s_r.ptr == $past(I_PWDATA[3:0]))
        else $error("Pointer write did not land");

    a_mem_write: assert property (
        wr_en && sel == SEL_DATA |=>
        s_r.mem[$past(s_r.ptr)] == $past(I_PWDATA[7:0]))
        else $error("Identifier byte write did not land");

    a_read_no_store: assert property (
        access && !I_PWRITE |=> $stable(s_r.mem))
        else $error("Read access changed the identifier store");

    a_hole_no_effect: assert property (
        access && sel == SEL_NONE |=>
        $stable(s_r.ctrl) && $stable(s_r.mem))
        else $error("Unmapped access changed state");

    // Only a data port access or a pointer write may move the pointer
    a_ptr_hold: assert property (
        !(access && (sel == SEL_DATA || sel == SEL_PTR)) |=>
        $stable(s_r.ptr))
        else $error("Pointer moved without a data access");

    a_ptr_wrap: assert property (
        access && sel == SEL_DATA && s_r.ptr == 4'hf |=>
        s_r.ptr == 4'h0)
        else $error("Pointer did not wrap to zero");

    // Stream side
    a_msb_order: assert property (
        push && s_r.ctrl == 4'b1000 |->
        push_byte[7] == cur_byte[7])
        else $error("Most significant bit not sent first");

    a_idle_align: assert property (
        push && s_r.ctrl == 4'b0100 |->
        push_byte == {s_r.tx_idx == 4'h0, 7'h00})
        else $error("Idle byte carries more than the alignment bit");

    a_invert_lsb: assert property (
        push && s_r.ctrl == 4'b1011 |->
        push_byte == ~reverse8(cur_byte))
        else $error("Reordered byte not inverted");

    // A full buffer must stall the producer or a byte is overwritten
    a_push_full: assert property (
        s_r.cnt == CW'(BUF_DEPTH) |-> !push)
        else $error("Byte pushed into a full buffer");

    a_buf_bound: assert property (
        s_r.cnt <= CW'(BUF_DEPTH))
        else $error("Buffer count beyond its depth");

    a_pop_advance: assert property (
        pop |=> s_r.rd == $past(s_r.rd) + AW'(1))
        else $error("Read slot did not advance after a transfer");

    a_reset_store: assert property (
        $past(I_SYS_RST) |-> s_r.tx_idx == '0 && s_r.mem == '0)
        else $error("Identifier store not cleared by reset");

    c_ptr_wrap:   cover property (access && sel == SEL_DATA &&
                                  s_r.ptr == 4'hf);
    c_buf_full:   cover property (O_TX_VALID && !I_TX_READY && !push);
    c_idle_send:  cover property (pop && s_r.ctrl.send_zero_identifier);
    c_lsb_invert: cover property (push && s_r.ctrl == 4'b0011);

endmodule // trail_trace_tx

// File: src/trail_trace_tx_params.svh
// Constants of the trail trace transmit block: register indices,
// field positions, widths and reset values.
// Assumes it is included by bare name wherever they are needed.
`ifndef TRAIL_TRACE_TX_PARAMS_SVH
`define TRAIL_TRACE_TX_PARAMS_SVH

// Register indices; byte address is four times the index
`define TT_CTRL_IDX        8'he8
`define TT_PTR_IDX         8'hea
`define TT_DATA_IDX        8'hec

// Control field positions
`define TT_ALIGN_DIS_BIT   3
`define TT_IDLE_BIT        2
`define TT_INVERT_BIT      1
`define TT_LSB_FIRST_BIT   0

// Widths
`define TT_CTRL_W          4
`define TT_PTR_W           4
`define TT_BYTE_W          8
`define TT_ID_BYTES        16

// Reset values
`define TT_CTRL_RST        4'h0
`define TT_PTR_RST         4'h0
`define TT_DATA_RST        8'h00

`endif

// File: src/trail_trace_tx_pkg.sv
// Types shared by the trail trace transmit block.
// Assumes the params header is compiled in the same unit.
`include "trail_trace_tx_params.svh"

package trail_trace_tx_pkg;

    // Field order follows the control register bits 3 down to 0
    typedef struct packed {
        logic align_insert_disable;
        logic send_zero_identifier;
        logic output_invert_enable;
        logic lsb_first_enable;
    } ctrl_type;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_CTRL,
        SEL_PTR,
        SEL_DATA
    } reg_sel_type;

endpackage

// File: tb/framer_sink_model.sv
// Framer overhead path model: takes one identifier byte per slot.
// Assumes the bench reads cnt_r and seen_r through the hierarchy.
`timescale 1ns/100ps
module framer_sink_model
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_valid,
    input  wire logic       i_slow,
    output logic            o_ready
);
    int         cnt_r;
    logic [7:0] seen_r [16];
    logic [1:0] ph_r;
    // Slow mode offers one slot in three, so the buffer must hold
    assign o_ready = !i_slow || (ph_r == 2'h0);
    always_ff @(posedge i_clk)
    begin
        ph_r <= (i_sys_rst || ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
        if (i_sys_rst)
            cnt_r <= 0;
        else if (i_valid && o_ready)
        begin
            seen_r[cnt_r % 16] <= i_byte;
            cnt_r              <= cnt_r + 1;
        end
    end
endmodule // framer_sink_model

// File: tb/trail_trace_tx_tb.sv
// Self-checking bench: APB master tasks and a framer model.
// Assumes the design, its package and the framer model are compiled.
`timescale 1ns/100ps
`include "trail_trace_tx_params.svh"
module trail_trace_tx_tb
    import trail_trace_tx_pkg::*;
;
    localparam logic [11:0] CTRL_A = {2'b00, `TT_CTRL_IDX, 2'b00};
    localparam logic [11:0] PTR_A  = {2'b00, `TT_PTR_IDX, 2'b00};
    localparam logic [11:0] DATA_A = {2'b00, `TT_DATA_IDX, 2'b00};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel, pen, pwr, pready, pslverr, txv, txr, slow, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  txb;
    logic [7:0]  ref_mem [16];
    int          error_cnt = 0;
    int          samples_checked = 0;

    always #5 clk = ~clk;

    trail_trace_tx trail_trace_tx_inst (.I_CLK(clk), .I_SYS_RST(rst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(4'hf), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .O_TX_BYTE(txb),
        .O_TX_VALID(txv), .I_TX_READY(txr));
    framer_sink_model framer_sink_model_inst (.i_clk(clk),
        .i_sys_rst(rst), .i_byte(txb), .i_valid(txv), .i_slow(slow),
        .o_ready(txr));

    task automatic end_sim;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, rd);
    endtask

    function automatic logic [7:0] exp_byte(input int i, input ctrl_type c);
        logic [7:0] b;
        b = c.send_zero_identifier ? 8'h00 : ref_mem[i];
        if (c.lsb_first_enable)
            b = {<<{b}};
        if (!c.align_insert_disable)
            b[7] = (i == 0);
        return c.output_invert_enable ? ~b : b;
    endfunction

    task automatic t_reset;
        rdchk(CTRL_A, 32'h0);
        rdchk(PTR_A, 32'h0);
        rdchk(DATA_A, 32'h0);
        rdchk(PTR_A, 32'h1);
    endtask

    task automatic t_load;
        apb(1'b1, PTR_A, 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            ref_mem[i] = 8'(8'h21 + 8'h13 * i);
            apb(1'b1, DATA_A, {24'h0, ref_mem[i]});
        end
        rdchk(PTR_A, 32'h0);
        for (int i = 0; i < 16; i++)
            rdchk(DATA_A, {24'h0, ref_mem[i]});
        apb(1'b1, PTR_A, 32'h5);
        rdchk(DATA_A, {24'h0, ref_mem[5]});
        rdchk(PTR_A, 32'h6);
    endtask

    task automatic t_reserved;
        apb(1'b1, CTRL_A, 32'hffff_fff0);
        rdchk(CTRL_A, 32'h0);
        apb(1'b1, PTR_A, 32'hffff_fff3);
        rdchk(PTR_A, 32'h3);
        apb(1'b0, 12'h3b8, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("hole", 32'h0, rd);
        chk("pready", 32'h1, {31'h0, pready});
    endtask

    // Every control mix; old buffered bytes are flushed before judging
    task automatic t_stream;
        int c0;
        for (int k = 0; k < 16; k++)
        begin
            slow <= k[0];
            apb(1'b1, CTRL_A, 32'(k));
            c0 = framer_sink_model_inst.cnt_r;
            while (framer_sink_model_inst.cnt_r < c0 + 20)
                @(posedge clk);
            for (int i = 0; i < 16; i++)
                chk("tx_byte", {24'h0, exp_byte(i, ctrl_type'(k[3:0]))},
                    {24'h0, framer_sink_model_inst.seen_r[i]});
        end
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim;
    end

    initial
    begin
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        slow = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_load;
        t_reserved;
        t_stream;
        end_sim;
    end
endmodule // trail_trace_tx_tb
